// File: pab_pkg.sv
// Shared constants and types for both ends of the parallel address/data bus port.
// Assumes one common bus clock; both ends import this package.
package pab_pkg;
	localparam int AD_W = 64;
	localparam int BE_W = 8;
	localparam int CTL_W = 5;
	// Bit positions of the active-low control lines within a control vector.
	localparam int C_FRAME = 0;
	localparam int C_IRDY = 1;
	localparam int C_TRDY = 2;
	localparam int C_STOP = 3;
	localparam int C_DEVSEL = 4;
	// Bus commands carried on the command/byte-enable lines in the address phase.
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'ha;
	localparam logic [3:0] CMD_CFG_WR = 4'hb;
	localparam int CMD_WR_BIT = 0;
	// Clocks a master waits for a claim before it gives up.
	localparam logic [2:0] MABORT_CLKS = 3'h5;
	localparam logic [63:0] STEP64 = 64'h8;
	localparam logic [63:0] STEP32 = 64'h4;
	localparam logic [63:0] LOW_MASK = 64'h0000_0000_ffff_ffff;
	// Per-half output enables, active low: bit 0 low half, bit 1 high half.
	localparam logic [1:0] LANES_ALL = 2'h0;
	localparam logic [1:0] LANES_LOW = 2'h2;
	localparam logic [1:0] LANES_OFF = 2'h3;
	// Transaction end status.
	localparam logic [1:0] ST_OK = 2'h0;
	localparam logic [1:0] ST_STOP = 2'h1;
	localparam logic [1:0] ST_ABORT = 2'h2;
	// Everything one agent drives onto the bus; an enable low means driving.
	typedef struct packed {
		logic [AD_W-1:0] ad;
		logic [1:0] ad_oe_n;
		logic [BE_W-1:0] cbe_n;
		logic [1:0] cbe_oe_n;
		logic [1:0] par;
		logic [1:0] par_oe_n;
		logic [CTL_W-1:0] ctl_n;
		logic [CTL_W-1:0] ctl_oe_n;
	} pab_drv_s;
	localparam pab_drv_s DRV_RST = '1;
endpackage : pab_pkg

// File: pab_if.sv
// Bus carrier joining the device end and the host end.
// Resolves each shared line from the two agents' enables; an undriven line reads high.
`timescale 1ns/1ps
`default_nettype none
interface pab_if (
	// Common bus clock.
	input wire logic clk
);
	import pab_pkg::*;
	pab_drv_s dev_drv;
	pab_drv_s hst_drv;
	logic idsel;
	logic [AD_W-1:0] ad;
	logic [BE_W-1:0] cbe_n;
	logic [1:0] par;
	logic [CTL_W-1:0] ctl_n;
	// Per-half resolution; the pull-up value stands in for a floating line.
	for (genvar i = 0; i < 2; i++)
	begin : g_half
		assign ad[32*i +: 32] = !dev_drv.ad_oe_n[i] ? dev_drv.ad[32*i +: 32] :
			!hst_drv.ad_oe_n[i] ? hst_drv.ad[32*i +: 32] : '1;
		assign cbe_n[4*i +: 4] = !dev_drv.cbe_oe_n[i] ? dev_drv.cbe_n[4*i +: 4] :
			!hst_drv.cbe_oe_n[i] ? hst_drv.cbe_n[4*i +: 4] : '1;
		assign par[i] = !dev_drv.par_oe_n[i] ? dev_drv.par[i] :
			!hst_drv.par_oe_n[i] ? hst_drv.par[i] : 1'b1;
	end
	// Control lines resolve one bit at a time.
	for (genvar j = 0; j < CTL_W; j++)
	begin : g_ctl
		assign ctl_n[j] = !dev_drv.ctl_oe_n[j] ? dev_drv.ctl_n[j] :
			!hst_drv.ctl_oe_n[j] ? hst_drv.ctl_n[j] : 1'b1;
	end
	modport dev (input clk, input ad, input cbe_n, input par, input ctl_n, input idsel,
		output dev_drv);
	modport hst (input clk, input ad, input cbe_n, input par, input ctl_n,
		output hst_drv, output idsel);
endinterface : pab_if
`default_nettype wire

// File: pab_dev.sv
// Device end of the bus port: one master engine and one target engine sharing the pins.
// Assumes the user owns the bus when it raises m_req; no arbitration is done here.
//
// What this block does
// - Address phase then one or more data phases.
// - Address phase is first FRAME low clock.
// - Address phase carries a full 64-bit address; with BUS64 off only the low 32 bits are driven and decoded.
// - Byte lane 0 is least significant.
// - Narrow bus leaves upper lanes undriven.
// - Command in address phase, byte enables after.
// - Enable bit n qualifies byte lane n.
// - Low parity covers low lanes, next clock.
// - Data parity lags data by one clock.
// - High parity covers upper lanes, same timing.
// - Parity driven by whoever drove the data.
// - Master holds FRAME until final data phase.
// - Phase completes when both ready lines low.
// - Initiator ready only with data or space.
// - Target ready only with data or space.
// - Master drives initiator ready, target drives target ready.
// - Target can stop; master obeys stop.
// - Config access answered only while IDSEL high.
// - Target claims with DEVSEL; master watches it.
// - Drive released control lines high one clock first.
// - Bus reset floats every bus output.
`timescale 1ns/1ps
`default_nettype none
module pab_dev #(
	parameter bit BUS64 = 1'b1,
	parameter int LEN_W = 8,
	parameter logic [63:0] MEM_BASE = 64'h0000_0000_1000_0000,
	parameter logic [63:0] MEM_MASK = 64'h0000_0000_0000_0fff
) (
	// Clock and bus reset.
	input wire logic clk,
	input wire logic rstn,
	// Shared bus.
	pab_if.dev bus,
	// Master request side.
	input wire logic m_req,
	input wire logic [3:0] m_cmd,
	input wire logic [pab_pkg::AD_W-1:0] m_addr,
	input wire logic [LEN_W-1:0] m_len,
	input wire logic [pab_pkg::AD_W-1:0] m_wdata,
	input wire logic [pab_pkg::BE_W-1:0] m_be,
	output logic m_busy,
	output logic [LEN_W-1:0] m_idx,
	output logic [pab_pkg::AD_W-1:0] m_rdata,
	output logic m_rvalid,
	output logic m_done,
	output logic [1:0] m_stat,
	// Target local side.
	output logic [pab_pkg::AD_W-1:0] t_addr,
	output logic t_cfg,
	output logic t_wr,
	input wire logic [pab_pkg::AD_W-1:0] t_rdata,
	input wire logic t_stop,
	output logic t_wstb,
	output logic [pab_pkg::AD_W-1:0] t_wdata,
	output logic [pab_pkg::BE_W-1:0] t_be
);
	import pab_pkg::*;
	typedef enum logic [2:0] {MS_IDLE, MS_ADDR, MS_DATA, MS_GAP, MS_TURN} pab_ms_e;
	typedef enum logic [1:0] {TS_IDLE, TS_WAIT, TS_DATA, TS_BACK} pab_ts_e;
	localparam logic [1:0] LANES_ON = BUS64 ? LANES_ALL : LANES_LOW;
	localparam logic [63:0] STEP = BUS64 ? STEP64 : STEP32;
	localparam logic [63:0] LANE_MASK = BUS64 ? '1 : LOW_MASK;

	pab_ms_e ms_reg, ms_next;
	pab_ts_e ts_reg, ts_next;
	pab_drv_s drv_reg, drv_next;
	logic frame_q_reg, wr_reg, wr_next, sel_reg, sel_next, busy_reg, busy_next;
	logic rvalid_reg, rvalid_next, done_reg, done_next, m_fin, t_fin;
	logic [LEN_W-1:0] len_reg, len_next, idx_reg, idx_next;
	logic [2:0] tmo_reg, tmo_next;
	logic [1:0] stat_reg, stat_next;
	logic [63:0] rdata_reg, rdata_next, taddr_reg, taddr_next, wdata_reg, wdata_next;
	logic tcfg_reg, tcfg_next, twr_reg, twr_next, wstb_reg, wstb_next;
	logic [BE_W-1:0] be_reg, be_next;

	// Decode of what the bus shows this clock.
	wire [3:0] acmd = bus.cbe_n[3:0];
	wire [63:0] addr_in = bus.ad & LANE_MASK;
	wire bus_idle = bus.ctl_n[C_FRAME] && bus.ctl_n[C_IRDY];
	wire addr_ph = frame_q_reg && !bus.ctl_n[C_FRAME];
	wire cfg_hit = (acmd == CMD_CFG_RD || acmd == CMD_CFG_WR) && bus.idsel;
	wire mem_hit = (acmd == CMD_MEM_RD || acmd == CMD_MEM_WR) &&
		((addr_in & ~MEM_MASK) == MEM_BASE);
	wire claim = addr_ph && ms_reg == MS_IDLE && ts_reg == TS_IDLE && (cfg_hit || mem_hit);
	wire beat_done = !bus.ctl_n[C_IRDY] && !bus.ctl_n[C_TRDY];
	wire last_beat = idx_reg == len_reg - LEN_W'(1);
	wire beat_load = ms_reg == MS_ADDR || ms_reg == MS_GAP;
	wire par_lo = ^{bus.ad[31:0], bus.cbe_n[3:0]};
	wire par_hi = ^{bus.ad[63:32], bus.cbe_n[7:4]};

	// Next-state logic for both engines; they never drive the pins at the same time.
	always_comb
	begin
		drv_next = drv_reg;
		drv_next.par = {par_hi, par_lo};
		drv_next.par_oe_n = drv_reg.ad_oe_n;
		ms_next = ms_reg;
		ts_next = ts_reg;
		wr_next = wr_reg;
		sel_next = sel_reg;
		busy_next = busy_reg;
		len_next = len_reg;
		idx_next = idx_reg;
		tmo_next = tmo_reg;
		stat_next = stat_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		done_next = 1'b0;
		taddr_next = taddr_reg;
		tcfg_next = tcfg_reg;
		twr_next = twr_reg;
		wstb_next = 1'b0;
		wdata_next = wdata_reg;
		be_next = be_reg;
		m_fin = 1'b0;
		t_fin = 1'b0;
		unique case (ms_reg)
			MS_IDLE:
			begin
				if (m_req && ts_reg == TS_IDLE && bus_idle)
				begin
					ms_next = MS_ADDR;
					busy_next = 1'b1;
					drv_next.ad = m_addr;
					drv_next.ad_oe_n = LANES_ON;
					drv_next.cbe_n = {m_cmd, m_cmd};
					drv_next.cbe_oe_n = LANES_ON;
					drv_next.ctl_n[C_FRAME] = 1'b0;
					drv_next.ctl_n[C_IRDY] = 1'b1;
					drv_next.ctl_oe_n[C_FRAME] = 1'b0;
					drv_next.ctl_oe_n[C_IRDY] = 1'b0;
					wr_next = m_cmd[CMD_WR_BIT];
					len_next = m_len;
					idx_next = '0;
					sel_next = 1'b0;
					tmo_next = '0;
					stat_next = ST_OK;
				end
			end
			MS_ADDR, MS_GAP:
			begin
				ms_next = MS_DATA;
			end
			MS_DATA:
			begin
				if (!bus.ctl_n[C_DEVSEL])
					sel_next = 1'b1;
				if (!sel_reg)
					tmo_next = tmo_reg + 3'h1;
				if (beat_done)
				begin
					idx_next = idx_reg + LEN_W'(1);
					rdata_next = addr_in;
					rvalid_next = !wr_reg;
					if (!bus.ctl_n[C_STOP])
						stat_next = ST_STOP;
					if (drv_reg.ctl_n[C_FRAME])
						m_fin = 1'b1;
					else
					begin
						// Initiator waits one clock so the next word can be fetched.
						ms_next = MS_GAP;
						drv_next.ctl_n[C_IRDY] = 1'b1;
					end
				end
				else if (!bus.ctl_n[C_STOP] || (!sel_reg && tmo_reg == MABORT_CLKS))
				begin
					stat_next = bus.ctl_n[C_STOP] ? ST_ABORT : ST_STOP;
					if (drv_reg.ctl_n[C_FRAME])
						m_fin = 1'b1;
					else
						drv_next.ctl_n[C_FRAME] = 1'b1;
				end
			end
			MS_TURN:
			begin
				ms_next = MS_IDLE;
				busy_next = 1'b0;
				drv_next.ctl_oe_n[C_FRAME] = 1'b1;
				drv_next.ctl_oe_n[C_IRDY] = 1'b1;
			end
		endcase
		if (beat_load)
		begin
			drv_next.ctl_n[C_FRAME] = last_beat || stat_reg == ST_STOP;
			drv_next.ctl_n[C_IRDY] = 1'b0;
			drv_next.cbe_n = ~m_be;
			drv_next.ad = m_wdata;
			drv_next.ad_oe_n = wr_reg ? LANES_ON : LANES_OFF;
		end
		if (m_fin)
		begin
			ms_next = MS_TURN;
			done_next = 1'b1;
			drv_next.ctl_n[C_IRDY] = 1'b1;
			drv_next.ad_oe_n = LANES_OFF;
			drv_next.cbe_oe_n = LANES_OFF;
		end
		unique case (ts_reg)
			TS_IDLE:
			begin
				if (claim)
				begin
					ts_next = acmd[CMD_WR_BIT] ? TS_DATA : TS_WAIT;
					taddr_next = addr_in;
					twr_next = acmd[CMD_WR_BIT];
					tcfg_next = cfg_hit;
					drv_next.ctl_n[C_DEVSEL] = 1'b0;
					drv_next.ctl_n[C_TRDY] = !acmd[CMD_WR_BIT];
					drv_next.ctl_n[C_STOP] = 1'b1;
					drv_next.ctl_oe_n[C_DEVSEL] = 1'b0;
					drv_next.ctl_oe_n[C_TRDY] = 1'b0;
					drv_next.ctl_oe_n[C_STOP] = 1'b0;
				end
			end
			TS_WAIT:
			begin
				ts_next = TS_DATA;
				drv_next.ad = t_rdata;
				drv_next.ad_oe_n = LANES_ON;
				drv_next.ctl_n[C_TRDY] = 1'b0;
			end
			TS_DATA:
			begin
				if (beat_done)
				begin
					taddr_next = taddr_reg + STEP;
					wstb_next = twr_reg;
					wdata_next = addr_in;
					be_next = ~bus.cbe_n;
				end
				if ((beat_done || !drv_reg.ctl_n[C_STOP]) && bus.ctl_n[C_FRAME])
					t_fin = 1'b1;
				else if (beat_done && (!drv_reg.ctl_n[C_STOP] || !twr_reg))
				begin
					drv_next.ctl_n[C_TRDY] = 1'b1;
					if (drv_reg.ctl_n[C_STOP])
						ts_next = TS_WAIT;
				end
				else if (t_stop)
					drv_next.ctl_n[C_STOP] = 1'b0;
			end
			TS_BACK:
			begin
				ts_next = TS_IDLE;
				drv_next.ctl_oe_n[C_DEVSEL] = 1'b1;
				drv_next.ctl_oe_n[C_TRDY] = 1'b1;
				drv_next.ctl_oe_n[C_STOP] = 1'b1;
			end
		endcase
		if (t_fin)
		begin
			ts_next = TS_BACK;
			drv_next.ctl_n[C_DEVSEL] = 1'b1;
			drv_next.ctl_n[C_TRDY] = 1'b1;
			drv_next.ctl_n[C_STOP] = 1'b1;
			drv_next.ad_oe_n = LANES_OFF;
		end
	end

	// State registers; reset floats every bus line without waiting for a clock.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			drv_reg <= DRV_RST;
			ms_reg <= MS_IDLE;
			ts_reg <= TS_IDLE;
			frame_q_reg <= 1'b1;
			{wr_reg, sel_reg, busy_reg, rvalid_reg, done_reg} <= '0;
			{len_reg, idx_reg, tmo_reg, stat_reg, rdata_reg} <= '0;
			{taddr_reg, tcfg_reg, twr_reg, wstb_reg, wdata_reg, be_reg} <= '0;
		end
		else
		begin
			drv_reg <= drv_next;
			ms_reg <= ms_next;
			ts_reg <= ts_next;
			frame_q_reg <= bus.ctl_n[C_FRAME];
			{wr_reg, sel_reg, busy_reg, rvalid_reg, done_reg} <=
				{wr_next, sel_next, busy_next, rvalid_next, done_next};
			{len_reg, idx_reg, tmo_reg, stat_reg, rdata_reg} <=
				{len_next, idx_next, tmo_next, stat_next, rdata_next};
			{taddr_reg, tcfg_reg, twr_reg, wstb_reg, wdata_reg, be_reg} <=
				{taddr_next, tcfg_next, twr_next, wstb_next, wdata_next, be_next};
		end
	end

	// Every output is a register.
	assign bus.dev_drv = drv_reg;
	assign m_busy = busy_reg;
	assign m_idx = idx_reg;
	assign m_rdata = rdata_reg;
	assign m_rvalid = rvalid_reg;
	assign m_done = done_reg;
	assign m_stat = stat_reg;
	assign t_addr = taddr_reg;
	assign t_cfg = tcfg_reg;
	assign t_wr = twr_reg;
	assign t_wstb = wstb_reg;
	assign t_wdata = wdata_reg;
	assign t_be = be_reg;
endmodule : pab_dev
`default_nettype wire

// File: pab_host.sv
// Host end of the bus port: single-phase master that also drives IDSEL, and a
// single-phase target that disconnects after each transferred word.
// Assumes it owns the bus whenever h_req is raised.
`timescale 1ns/1ps
`default_nettype none
module pab_host #(
	parameter logic [63:0] HT_BASE = 64'h0000_0000_2000_0000,
	parameter logic [63:0] HT_MASK = 64'h0000_0000_0000_0fff
) (
	// Clock and bus reset.
	input wire logic clk,
	input wire logic rstn,
	// Shared bus.
	pab_if.hst bus,
	// Master request side.
	input wire logic h_req,
	input wire logic [3:0] h_cmd,
	input wire logic h_idsel,
	input wire logic [pab_pkg::AD_W-1:0] h_addr,
	input wire logic [pab_pkg::AD_W-1:0] h_wdata,
	input wire logic [pab_pkg::BE_W-1:0] h_be,
	output logic h_busy,
	output logic [pab_pkg::AD_W-1:0] h_rdata,
	output logic h_done,
	output logic [1:0] h_stat,
	// Target local side.
	output logic [pab_pkg::AD_W-1:0] ht_addr,
	input wire logic [pab_pkg::AD_W-1:0] ht_rdata,
	output logic ht_wstb,
	output logic [pab_pkg::AD_W-1:0] ht_wdata,
	output logic [pab_pkg::BE_W-1:0] ht_be
);
	import pab_pkg::*;
	typedef enum logic [1:0] {HM_IDLE, HM_ADDR, HM_DATA, HM_TURN} pab_hm_e;
	typedef enum logic [1:0] {HT_IDLE, HT_WAIT, HT_DATA, HT_BACK} pab_ht_e;

	pab_hm_e hm_reg, hm_next;
	pab_ht_e ht_reg, ht_next;
	pab_drv_s drv_reg, drv_next;
	logic frame_q_reg, idsel_reg, idsel_next, wr_reg, wr_next, sel_reg, sel_next;
	logic busy_reg, busy_next, done_reg, done_next, wstb_reg, wstb_next, twr_reg, twr_next;
	logic [2:0] tmo_reg, tmo_next;
	logic [1:0] stat_reg, stat_next;
	logic [63:0] rdata_reg, rdata_next, taddr_reg, taddr_next, wdata_reg, wdata_next;
	logic [BE_W-1:0] be_reg, be_next;

	// Decode of the bus this clock.
	wire [3:0] acmd = bus.cbe_n[3:0];
	wire beat_done = !bus.ctl_n[C_IRDY] && !bus.ctl_n[C_TRDY];
	wire claim = frame_q_reg && !bus.ctl_n[C_FRAME] && hm_reg == HM_IDLE &&
		(acmd == CMD_MEM_RD || acmd == CMD_MEM_WR) && ((bus.ad & ~HT_MASK) == HT_BASE);

	// Next-state logic; parity always trails the data this end drove.
	always_comb
	begin
		drv_next = drv_reg;
		drv_next.par = {^{bus.ad[63:32], bus.cbe_n[7:4]}, ^{bus.ad[31:0], bus.cbe_n[3:0]}};
		drv_next.par_oe_n = drv_reg.ad_oe_n;
		{hm_next, ht_next, idsel_next, wr_next, sel_next} =
			{hm_reg, ht_reg, idsel_reg, wr_reg, sel_reg};
		{busy_next, tmo_next, stat_next, rdata_next} = {busy_reg, tmo_reg, stat_reg, rdata_reg};
		{taddr_next, twr_next, wdata_next, be_next} = {taddr_reg, twr_reg, wdata_reg, be_reg};
		done_next = 1'b0;
		wstb_next = 1'b0;
		unique case (hm_reg)
			HM_IDLE:
			begin
				if (h_req && ht_reg == HT_IDLE && bus.ctl_n[C_FRAME] && bus.ctl_n[C_IRDY])
				begin
					hm_next = HM_ADDR;
					busy_next = 1'b1;
					idsel_next = h_idsel && (h_cmd == CMD_CFG_RD || h_cmd == CMD_CFG_WR);
					drv_next.ad = h_addr;
					drv_next.ad_oe_n = LANES_ALL;
					drv_next.cbe_n = {h_cmd, h_cmd};
					drv_next.cbe_oe_n = LANES_ALL;
					drv_next.ctl_n[C_FRAME] = 1'b0;
					drv_next.ctl_n[C_IRDY] = 1'b1;
					drv_next.ctl_oe_n[C_FRAME] = 1'b0;
					drv_next.ctl_oe_n[C_IRDY] = 1'b0;
					wr_next = h_cmd[CMD_WR_BIT];
					{sel_next, tmo_next, stat_next} = '0;
				end
			end
			HM_ADDR:
			begin
				// Single data phase, so FRAME rises as IRDY falls.
				hm_next = HM_DATA;
				idsel_next = 1'b0;
				drv_next.ctl_n[C_FRAME] = 1'b1;
				drv_next.ctl_n[C_IRDY] = 1'b0;
				drv_next.cbe_n = ~h_be;
				drv_next.ad = h_wdata;
				drv_next.ad_oe_n = wr_reg ? LANES_ALL : LANES_OFF;
			end
			HM_DATA:
			begin
				if (!bus.ctl_n[C_DEVSEL])
					sel_next = 1'b1;
				if (!sel_reg)
					tmo_next = tmo_reg + 3'h1;
				if (beat_done)
					rdata_next = bus.ad;
				if (beat_done || !bus.ctl_n[C_STOP] || (!sel_reg && tmo_reg == MABORT_CLKS))
				begin
					hm_next = HM_TURN;
					done_next = 1'b1;
					stat_next = !bus.ctl_n[C_STOP] ? ST_STOP : beat_done ? ST_OK : ST_ABORT;
					drv_next.ctl_n[C_IRDY] = 1'b1;
					drv_next.ad_oe_n = LANES_OFF;
					drv_next.cbe_oe_n = LANES_OFF;
				end
			end
			HM_TURN:
			begin
				hm_next = HM_IDLE;
				busy_next = 1'b0;
				drv_next.ctl_oe_n[C_FRAME] = 1'b1;
				drv_next.ctl_oe_n[C_IRDY] = 1'b1;
			end
		endcase
		unique case (ht_reg)
			HT_IDLE:
			begin
				if (claim)
				begin
					ht_next = acmd[CMD_WR_BIT] ? HT_DATA : HT_WAIT;
					taddr_next = bus.ad;
					twr_next = acmd[CMD_WR_BIT];
					drv_next.ctl_n[C_DEVSEL] = 1'b0;
					drv_next.ctl_n[C_TRDY] = !acmd[CMD_WR_BIT];
					drv_next.ctl_n[C_STOP] = !acmd[CMD_WR_BIT];
					drv_next.ctl_oe_n[C_DEVSEL] = 1'b0;
					drv_next.ctl_oe_n[C_TRDY] = 1'b0;
					drv_next.ctl_oe_n[C_STOP] = 1'b0;
				end
			end
			HT_WAIT:
			begin
				ht_next = HT_DATA;
				drv_next.ad = ht_rdata;
				drv_next.ad_oe_n = LANES_ALL;
				drv_next.ctl_n[C_TRDY] = 1'b0;
				drv_next.ctl_n[C_STOP] = 1'b0;
			end
			HT_DATA:
			begin
				// Disconnect with the first word; STOP stays until FRAME is high.
				if (beat_done)
				begin
					wstb_next = twr_reg;
					wdata_next = bus.ad;
					be_next = ~bus.cbe_n;
					drv_next.ctl_n[C_TRDY] = 1'b1;
					drv_next.ctl_n[C_STOP] = 1'b0;
				end
				if (bus.ctl_n[C_FRAME] && (beat_done || !drv_reg.ctl_n[C_STOP]))
				begin
					ht_next = HT_BACK;
					drv_next.ctl_n[C_DEVSEL] = 1'b1;
					drv_next.ctl_n[C_TRDY] = 1'b1;
					drv_next.ctl_n[C_STOP] = 1'b1;
					drv_next.ad_oe_n = LANES_OFF;
				end
			end
			HT_BACK:
			begin
				ht_next = HT_IDLE;
				drv_next.ctl_oe_n[C_DEVSEL] = 1'b1;
				drv_next.ctl_oe_n[C_TRDY] = 1'b1;
				drv_next.ctl_oe_n[C_STOP] = 1'b1;
			end
		endcase
	end

	// State registers; reset floats the bus at once.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			drv_reg <= DRV_RST;
			hm_reg <= HM_IDLE;
			ht_reg <= HT_IDLE;
			frame_q_reg <= 1'b1;
			{idsel_reg, wr_reg, sel_reg, busy_reg, done_reg, wstb_reg, twr_reg} <= '0;
			{tmo_reg, stat_reg, rdata_reg, taddr_reg, wdata_reg, be_reg} <= '0;
		end
		else
		begin
			drv_reg <= drv_next;
			hm_reg <= hm_next;
			ht_reg <= ht_next;
			frame_q_reg <= bus.ctl_n[C_FRAME];
			{idsel_reg, wr_reg, sel_reg, busy_reg, done_reg, wstb_reg, twr_reg} <=
				{idsel_next, wr_next, sel_next, busy_next, done_next, wstb_next, twr_next};
			{tmo_reg, stat_reg, rdata_reg, taddr_reg, wdata_reg, be_reg} <=
				{tmo_next, stat_next, rdata_next, taddr_next, wdata_next, be_next};
		end
	end

	// Outputs straight from registers.
	assign bus.hst_drv = drv_reg;
	assign bus.idsel = idsel_reg;
	assign h_busy = busy_reg;
	assign h_rdata = rdata_reg;
	assign h_done = done_reg;
	assign h_stat = stat_reg;
	assign ht_addr = taddr_reg;
	assign ht_wstb = wstb_reg;
	assign ht_wdata = wdata_reg;
	assign ht_be = be_reg;
endmodule : pab_host
`default_nettype wire

// File: pab_chk.sv
// Checker for the shared bus lines between the two port ends.
// Assumes resolved lines read high when undriven; one bus clock.
`timescale 1ns/1ps
`default_nettype none
module pab_chk (
	// Bus clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Resolved bus lines.
	input wire logic [pab_pkg::AD_W-1:0] ad,
	input wire logic [pab_pkg::BE_W-1:0] cbe_n,
	input wire logic [1:0] par,
	input wire logic [pab_pkg::CTL_W-1:0] ctl_n,
	input wire logic idsel
);
	import pab_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Parity as a receiver recomputes it; a lag lets the driver register it.
	wire logic p_lo = ^{ad[31:0], cbe_n[3:0]};
	wire logic p_hi = ^{ad[63:32], cbe_n[7:4]};
	// Address phase opens a transfer; a data phase ends on both ready lines low.
	sequence s_addr;
		$fell(ctl_n[C_FRAME]);
	endsequence
	sequence s_done;
		!ctl_n[C_IRDY] && !ctl_n[C_TRDY];
	endsequence
	a_addr_par_lo: assert property (s_addr |=> par[0] == $past(p_lo))
		else $error("low address parity wrong");
	a_addr_par_hi: assert property (s_addr |=> par[1] == $past(p_hi))
		else $error("high address parity wrong");
	a_data_par: assert property (s_done |=> par == {$past(p_hi), $past(p_lo)})
		else $error("data parity wrong");
	a_addr_no_data: assert property (s_addr |-> ctl_n[C_IRDY] && ctl_n[C_TRDY])
		else $error("ready asserted in address phase");
	a_frame_final: assert property ($rose(ctl_n[C_FRAME]) |-> !ctl_n[C_IRDY])
		else $error("frame released outside final phase");
	a_final_reached: assert property (s_addr |-> ##[1:16] (ctl_n[C_FRAME] && !ctl_n[C_IRDY]))
		else $error("no final data phase");
	a_claim_done: assert property (s_done |-> !ctl_n[C_DEVSEL])
		else $error("data moved without a claim");
	a_stop_ends: assert property ($fell(ctl_n[C_STOP]) |-> ##[0:3] ctl_n[C_FRAME])
		else $error("master ignored stop");
	a_cfg_select: assert property (s_addr ##0 (cbe_n[3:1] == CMD_CFG_RD[3:1] && !idsel)
		|=> ctl_n[C_DEVSEL] [*4]) else $error("config claimed without select");
	a_rst_float: assert property (disable iff (1'b0) !rstn |-> ctl_n == '1 && ad == '1)
		else $error("bus driven in reset");
endmodule : pab_chk
`default_nettype wire

// File: tb_pci_addr_data_ctrl_port.sv
// Bench joining the device end and the host end across one carrier.
// Assumes the package defaults; transfers are issued one at a time.
`timescale 1ns/1ps
`default_nettype none
module tb_pci_addr_data_ctrl_port;
	import pab_pkg::*;
	localparam logic [63:0] MB = 64'h0000_0000_1000_0000;
	localparam logic [63:0] HB = 64'h0000_0000_2000_0000;
	localparam logic [63:0] K = 64'hffff_0000_0000_ffff;
	localparam logic [63:0] WD = 64'h1122_3344_5566_7788;
	logic clk = 1'b0;
	logic rstn = 1'b1;
	logic m_req = 1'b0, h_req = 1'b0, h_idsel = 1'b0, t_stop = 1'b0;
	logic [3:0] m_cmd = 4'h0, h_cmd = 4'h0;
	logic [63:0] m_addr = 64'h0, h_addr = 64'h0, h_wdata = WD;
	logic [7:0] m_len = 8'h1, m_be = 8'hf0, h_be = 8'h3c;
	logic m_busy, m_rvalid, m_done, t_cfg, t_wr, t_wstb, h_busy, h_done, ht_wstb, lw_c;
	logic [7:0] m_idx, t_be, ht_be, lw_b, hw_b;
	logic [1:0] m_stat, h_stat;
	logic [63:0] m_rdata, m_wdata, t_addr, t_rdata, t_wdata, h_rdata;
	logic [63:0] ht_addr, ht_rdata, ht_wdata, lw_d, hw_d;
	int error_cnt = 0;
	int checks_done = 0;
	int rv_n = 0;
	// Local data follow the index or address so a lane or beat slip shows.
	assign m_wdata = WD ^ {56'h0, m_idx};
	assign t_rdata = t_addr ^ K;
	assign ht_rdata = ~ht_addr;
	// Free-running bus clock.
	initial forever #10 clk = ~clk;
	pab_if pab_if_inst (.clk(clk));
	pab_dev #(.BUS64(1'b1), .LEN_W(8), .MEM_BASE(MB), .MEM_MASK(64'hfff)) pab_dev_inst (
		.clk(clk), .rstn(rstn), .bus(pab_if_inst), .m_req(m_req), .m_cmd(m_cmd),
		.m_addr(m_addr), .m_len(m_len), .m_wdata(m_wdata), .m_be(m_be), .m_busy(m_busy),
		.m_idx(m_idx), .m_rdata(m_rdata), .m_rvalid(m_rvalid), .m_done(m_done),
		.m_stat(m_stat), .t_addr(t_addr), .t_cfg(t_cfg), .t_wr(t_wr), .t_rdata(t_rdata),
		.t_stop(t_stop), .t_wstb(t_wstb), .t_wdata(t_wdata), .t_be(t_be));
	pab_host #(.HT_BASE(HB), .HT_MASK(64'hfff)) pab_host_inst (
		.clk(clk), .rstn(rstn), .bus(pab_if_inst), .h_req(h_req), .h_cmd(h_cmd),
		.h_idsel(h_idsel), .h_addr(h_addr), .h_wdata(h_wdata), .h_be(h_be),
		.h_busy(h_busy), .h_rdata(h_rdata), .h_done(h_done), .h_stat(h_stat),
		.ht_addr(ht_addr), .ht_rdata(ht_rdata), .ht_wstb(ht_wstb), .ht_wdata(ht_wdata),
		.ht_be(ht_be));
	pab_chk pab_chk_inst (.clk(clk), .rstn(rstn), .ad(pab_if_inst.ad),
		.cbe_n(pab_if_inst.cbe_n), .par(pab_if_inst.par), .ctl_n(pab_if_inst.ctl_n),
		.idsel(pab_if_inst.idsel));
	// Keep the last word each target handed to its local side, and count read words.
	// Sampled mid-cycle so a check made at the next rising edge already sees the copy.
	always @(negedge clk)
	begin
		if (m_rvalid === 1'b1)
			rv_n <= rv_n + 1;
		if (t_wstb === 1'b1)
		begin
			lw_d <= t_wdata;
			lw_b <= t_be;
			lw_c <= t_cfg;
		end
		if (ht_wstb === 1'b1)
		begin
			hw_d <= ht_wdata;
			hw_b <= ht_be;
		end
	end
	task automatic conclude;
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	task automatic tmo;
		error_cnt++;
		conclude();
	endtask : tmo
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h got %h", nm, e, g);
		end
	endtask : chk
	// Both ends quiet and every control line high, so no turnaround is cut short.
	task automatic idle;
		int n;
		for (n = 0; n < 60 && (m_busy !== 1'b0 || h_busy !== 1'b0 || pab_if_inst.ctl_n !== '1); n++)
			@(posedge clk);
		if (n == 60)
			tmo();
		@(posedge clk);
	endtask : idle
	task automatic hop(input logic [3:0] c, input logic s, input logic [63:0] a, input logic [1:0] st);
		int n;
		idle();
		h_req <= 1'b1;
		h_cmd <= c;
		h_idsel <= s;
		h_addr <= a;
		@(posedge clk);
		h_req <= 1'b0;
		for (n = 0; n < 60 && h_done !== 1'b1; n++)
			@(posedge clk);
		if (n == 60)
			tmo();
		chk("h_stat", 64'(st), 64'(h_stat));
	endtask : hop
	task automatic dop(input logic [3:0] c, input logic [63:0] a, input logic [7:0] l,
		input logic [1:0] st, input logic [7:0] ix);
		int n;
		idle();
		m_req <= 1'b1;
		m_cmd <= c;
		m_addr <= a;
		m_len <= l;
		@(posedge clk);
		m_req <= 1'b0;
		for (n = 0; n < 60 && m_done !== 1'b1; n++)
			@(posedge clk);
		if (n == 60)
			tmo();
		chk("m_stat", 64'(st), 64'(m_stat));
		chk("m_idx", 64'(ix), 64'(m_idx));
	endtask : dop
	// Main sequence: host-initiated, then device-initiated, then a reset in mid-run.
	initial
	begin
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		hop(CMD_MEM_WR, 1'b0, MB + 64'h20, ST_OK);
		chk("t_wdata", WD, lw_d);
		chk("t_be", 64'(h_be), 64'(lw_b));
		chk("t_addr", MB + 64'h28, t_addr);
		chk("t_wr", 64'h1, 64'(t_wr));
		hop(CMD_MEM_RD, 1'b0, MB + 64'h28, ST_OK);
		chk("h_rdata", (MB + 64'h28) ^ K, h_rdata);
		hop(CMD_CFG_WR, 1'b1, 64'h10, ST_OK);
		chk("t_cfg", 64'h1, 64'(lw_c));
		hop(CMD_CFG_RD, 1'b1, 64'h18, ST_OK);
		chk("h_rdata", 64'h18 ^ K, h_rdata);
		hop(CMD_CFG_RD, 1'b0, 64'h18, ST_ABORT);
		hop(CMD_CFG_WR, 1'b0, 64'h18, ST_ABORT);
		hop(CMD_IO_RD, 1'b0, MB, ST_ABORT);
		hop(CMD_IO_WR, 1'b0, MB, ST_ABORT);
		dop(CMD_MEM_WR, HB + 64'h40, 8'h2, ST_STOP, 8'h1);
		chk("ht_wdata", WD, hw_d);
		chk("ht_be", 64'(m_be), 64'(hw_b));
		chk("ht_addr", HB + 64'h40, ht_addr);
		// The host target disconnects with its only word, so the status shows the stop.
		dop(CMD_MEM_RD, HB + 64'h48, 8'h1, ST_STOP, 8'h1);
		chk("m_rdata", ~(HB + 64'h48), m_rdata);
		chk("m_rvalid", 64'h1, 64'(rv_n));
		dop(CMD_MEM_RD, 64'h3000_0000, 8'h1, ST_ABORT, 8'h0);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		hop(CMD_MEM_WR, 1'b0, MB + 64'h30, ST_OK);
		conclude();
	end
endmodule : tb_pci_addr_data_ctrl_port
`default_nettype wire
